// file: pft_consts.svh
`ifndef PFT_CONSTS_SVH
`define PFT_CONSTS_SVH

`define PFT_ADDR_W      32
`define PFT_CC_W        16
`define PFT_CNT_W       8
`define PFT_CC_THRESH   16
`define PFT_CC_FIRST    0
`define PFT_CC_RESET    1

`endif

// file: pft_pkg.sv
package pft_pkg;
    typedef enum logic [3:0] {
        PFT_EL_NONE       = 4'h0,
        PFT_EL_TRACE_INFO = 4'h1,
        PFT_EL_TRACE_ON   = 4'h2,
        PFT_EL_CONTEXT    = 4'h3,
        PFT_EL_ADDRESS    = 4'h4,
        PFT_EL_ATOM_E     = 4'h5,
        PFT_EL_ATOM_N     = 4'h6,
        PFT_EL_COMMIT     = 4'h7,
        PFT_EL_CYCLE_CNT  = 4'h8
    } pft_elem_t;

    // Gray along idle -> info -> on -> context -> address -> tracing
    typedef enum logic [2:0] {
        PFT_ST_IDLE    = 3'b000,
        PFT_ST_INFO    = 3'b001,
        PFT_ST_ON      = 3'b011,
        PFT_ST_CONTEXT = 3'b010,
        PFT_ST_ADDRESS = 3'b110,
        PFT_ST_TRACE   = 3'b111
    } pft_state_t;
endpackage

// file: pft_cc_if.sv
`timescale 1ns/1ns
interface pft_cc_if #(parameter int CC_W = 16);
    logic            enable;
    logic            commit;
    logic [CC_W-1:0] threshold;
    logic            emit;
    logic [CC_W-1:0] value;
    modport owner (output enable, output commit, output threshold, input emit, input value);
    modport counter (input enable, input commit, input threshold, output emit, output value);
endinterface

// file: pft_cycle_counter.sv
`timescale 1ns/1ns
`include "pft_consts.svh"
module pft_cycle_counter
    import pft_pkg::*;
#(
    parameter int CC_W = `PFT_CC_W
) (
    input  wire logic ref_clk,
    input  wire logic reset_n,
    pft_cc_if.counter cc
);
    logic [CC_W-1:0] elapsed_reg;
    logic [CC_W-1:0] elapsed_next;
    logic            first_reg;
    logic            first_next;
    logic            hold_en_reg;
    logic            hold_en_next;

    // Emit on first commit, or when elapsed passes the threshold
    assign cc.emit = cc.enable && cc.commit &&
                     (first_reg || (elapsed_reg > cc.threshold));
    // First count unknown, so report zero
    assign cc.value = first_reg ? CC_W'(`PFT_CC_FIRST) : elapsed_reg;

    always_comb begin
        elapsed_next = elapsed_reg;
        first_next   = first_reg;
        hold_en_next = cc.enable;
        if (!cc.enable) begin
            first_next   = 1'b1;
            elapsed_next = CC_W'(`PFT_CC_RESET);
        end else if (cc.emit) begin
            first_next   = 1'b0;
            elapsed_next = CC_W'(`PFT_CC_RESET);
        end else if (elapsed_reg != {CC_W{1'b1}}) begin
            // Saturate rather than wrap so a long gap never looks short
            elapsed_next = elapsed_reg + CC_W'(1);
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            elapsed_reg <= CC_W'(`PFT_CC_RESET);
            first_reg   <= 1'b1;
            hold_en_reg <= 1'b0;
        end else begin
            elapsed_reg <= elapsed_next;
            first_reg   <= first_next;
            hold_en_reg <= hold_en_next;
        end
    end

    a_cc_restart: assert property (@(posedge ref_clk) disable iff (!reset_n)
        cc.emit && hold_en_reg |=> elapsed_reg == CC_W'(`PFT_CC_RESET))
        else $error("elapsed count not restarted after cycle count");
endmodule

// file: pft_trace_unit.sv
`timescale 1ns/1ns
`include "pft_consts.svh"
module pft_trace_unit
    import pft_pkg::*;
#(
    parameter int ADDR_W = `PFT_ADDR_W,
    parameter int CC_W   = `PFT_CC_W,
    parameter int CNT_W  = `PFT_CNT_W
) (
    input  wire logic              ref_clk,
    input  wire logic              reset_n,
    input  wire logic              trace_enable,
    input  wire logic              start_addr_enable,
    input  wire logic [ADDR_W-1:0] start_addr,
    input  wire logic              cc_enable,
    input  wire logic [CC_W-1:0]   cc_threshold,
    input  wire logic              insn_valid,
    input  wire logic [ADDR_W-1:0] insn_addr,
    input  wire logic              insn_is_branch,
    input  wire logic              insn_taken,
    input  wire logic              commit_valid,
    input  wire logic [CNT_W-1:0]  commit_count,
    output logic                   insn_ready,
    output logic                   commit_ready,
    output logic                   elem_valid,
    output pft_elem_t              elem_kind,
    output logic [ADDR_W-1:0]      elem_payload,
    output logic                   tracing
);
    pft_state_t              state_reg;
    pft_state_t              state_next;
    logic [ADDR_W-1:0]       addr_reg;
    logic [ADDR_W-1:0]       addr_next;
    logic                    pend_reg;
    logic                    pend_next;
    logic                    pend_taken_reg;
    logic                    pend_taken_next;
    logic                    cc_pend_reg;
    logic                    cc_pend_next;
    logic [CC_W-1:0]         cc_val_reg;
    logic [CC_W-1:0]         cc_val_next;
    logic                    elem_valid_reg;
    logic                    elem_valid_next;
    pft_elem_t               elem_kind_reg;
    pft_elem_t               elem_kind_next;
    logic [ADDR_W-1:0]       elem_payload_reg;
    logic [ADDR_W-1:0]       elem_payload_next;
    logic                    start_hit;
    logic                    insn_take;
    logic                    commit_take;

    pft_cc_if #(.CC_W(CC_W)) cc ();

    pft_cycle_counter #(.CC_W(CC_W)) u_cc (
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .cc      (cc)
    );

    // Core stalls while start sequence or a pending atom/cycle count is output
    assign insn_ready   = trace_enable && !pend_reg && !cc_pend_reg &&
                          (state_reg == PFT_ST_IDLE || state_reg == PFT_ST_TRACE);
    assign commit_ready = (state_reg == PFT_ST_TRACE) && !pend_reg && !cc_pend_reg;
    assign insn_take    = insn_valid && insn_ready;
    assign commit_take  = commit_valid && commit_ready;
    assign start_hit    = insn_take && (state_reg == PFT_ST_IDLE) &&
                          (!start_addr_enable || insn_addr == start_addr);

    assign cc.enable    = cc_enable && (state_reg == PFT_ST_TRACE);
    assign cc.commit    = commit_take;
    assign cc.threshold = cc_threshold;

    assign elem_valid   = elem_valid_reg;
    assign elem_kind    = elem_kind_reg;
    assign elem_payload = elem_payload_reg;
    assign tracing      = (state_reg != PFT_ST_IDLE);

    always_comb begin
        state_next        = state_reg;
        addr_next         = addr_reg;
        pend_next         = pend_reg;
        pend_taken_next   = pend_taken_reg;
        cc_pend_next      = cc_pend_reg;
        cc_val_next       = cc_val_reg;
        elem_valid_next   = 1'b0;
        elem_kind_next    = PFT_EL_NONE;
        elem_payload_next = '0;
        case (state_reg)
            PFT_ST_IDLE: begin
                if (start_hit) begin
                    state_next      = PFT_ST_INFO;
                    addr_next       = insn_addr;
                    // First instruction's atom held back until the start set is out
                    pend_next       = insn_is_branch;
                    pend_taken_next = insn_taken;
                end
            end
            PFT_ST_INFO: begin
                elem_valid_next = 1'b1;
                elem_kind_next  = PFT_EL_TRACE_INFO;
                state_next      = PFT_ST_ON;
            end
            PFT_ST_ON: begin
                elem_valid_next = 1'b1;
                elem_kind_next  = PFT_EL_TRACE_ON;
                state_next      = PFT_ST_CONTEXT;
            end
            PFT_ST_CONTEXT: begin
                elem_valid_next = 1'b1;
                elem_kind_next  = PFT_EL_CONTEXT;
                state_next      = PFT_ST_ADDRESS;
            end
            PFT_ST_ADDRESS: begin
                elem_valid_next   = 1'b1;
                elem_kind_next    = PFT_EL_ADDRESS;
                elem_payload_next = addr_reg;
                state_next        = PFT_ST_TRACE;
            end
            PFT_ST_TRACE: begin
                if (!trace_enable) begin
                    state_next   = PFT_ST_IDLE;
                    pend_next    = 1'b0;
                    cc_pend_next = 1'b0;
                end else if (pend_reg) begin
                    elem_valid_next = 1'b1;
                    elem_kind_next  = pend_taken_reg ? PFT_EL_ATOM_E : PFT_EL_ATOM_N;
                    pend_next       = 1'b0;
                end else if (cc_pend_reg) begin
                    elem_valid_next   = 1'b1;
                    elem_kind_next    = PFT_EL_CYCLE_CNT;
                    elem_payload_next = ADDR_W'(cc_val_reg);
                    cc_pend_next      = 1'b0;
                end else if (commit_take) begin
                    elem_valid_next   = 1'b1;
                    elem_kind_next    = PFT_EL_COMMIT;
                    elem_payload_next = ADDR_W'(commit_count);
                    cc_pend_next      = cc.emit;
                    cc_val_next       = cc.value;
                end else if (insn_take && insn_is_branch) begin
                    // Atoms imply all non-branch work since the last one
                    elem_valid_next = 1'b1;
                    elem_kind_next  = insn_taken ? PFT_EL_ATOM_E : PFT_EL_ATOM_N;
                end
                // Non-branch instructions fall through with no element
            end
            default: begin
                state_next = PFT_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg        <= PFT_ST_IDLE;
            addr_reg         <= '0;
            pend_reg         <= 1'b0;
            pend_taken_reg   <= 1'b0;
            cc_pend_reg      <= 1'b0;
            cc_val_reg       <= '0;
            elem_valid_reg   <= 1'b0;
            elem_kind_reg    <= PFT_EL_NONE;
            elem_payload_reg <= '0;
        end else begin
            state_reg        <= state_next;
            addr_reg         <= addr_next;
            pend_reg         <= pend_next;
            pend_taken_reg   <= pend_taken_next;
            cc_pend_reg      <= cc_pend_next;
            cc_val_reg       <= cc_val_next;
            elem_valid_reg   <= elem_valid_next;
            elem_kind_reg    <= elem_kind_next;
            elem_payload_reg <= elem_payload_next;
        end
    end

    sequence s_start_set;
        elem_kind == PFT_EL_TRACE_INFO ##1 elem_kind == PFT_EL_TRACE_ON
        ##1 elem_kind == PFT_EL_CONTEXT ##1 elem_kind == PFT_EL_ADDRESS;
    endsequence

    sequence s_commit_then_cc;
        elem_kind == PFT_EL_COMMIT ##1 elem_kind == PFT_EL_CYCLE_CNT;
    endsequence

    a_start_order: assert property (@(posedge ref_clk) disable iff (!reset_n)
        start_hit |-> ##2 s_start_set) else $error("start set out of order");

    a_start_addr: assert property (@(posedge ref_clk) disable iff (!reset_n)
        insn_take && state_reg == PFT_ST_IDLE && start_addr_enable && insn_addr != start_addr
        |=> !tracing)
        else $error("trace started at wrong address");

    a_atom_taken: assert property (@(posedge ref_clk) disable iff (!reset_n)
        state_reg == PFT_ST_TRACE && trace_enable && !pend_reg && !cc_pend_reg && !commit_valid
        && insn_valid && insn_is_branch && insn_taken |=> elem_kind == PFT_EL_ATOM_E)
        else $error("taken branch without executed atom");

    a_atom_not_taken: assert property (@(posedge ref_clk) disable iff (!reset_n)
        state_reg == PFT_ST_TRACE && trace_enable && !pend_reg && !cc_pend_reg && !commit_valid
        && insn_valid && insn_is_branch && !insn_taken |=> elem_kind == PFT_EL_ATOM_N)
        else $error("untaken branch without not-executed atom");

    a_no_plain_elem: assert property (@(posedge ref_clk) disable iff (!reset_n)
        state_reg == PFT_ST_TRACE && !pend_reg && !cc_pend_reg && !commit_valid
        && insn_valid && !insn_is_branch |=> !elem_valid)
        else $error("non-branch produced an element");

    a_commit_count: assert property (@(posedge ref_clk) disable iff (!reset_n)
        commit_take && trace_enable |=> elem_kind == PFT_EL_COMMIT
        && elem_payload == ADDR_W'($past(commit_count)))
        else $error("commit element missing or wrong count");

    a_cc_follows: assert property (@(posedge ref_clk) disable iff (!reset_n)
        commit_take && trace_enable && cc.emit |=> s_commit_then_cc)
        else $error("cycle count not attached to commit");

    a_cc_suppress: assert property (@(posedge ref_clk) disable iff (!reset_n)
        commit_take && trace_enable && !cc.emit |=> ##1 elem_kind != PFT_EL_CYCLE_CNT)
        else $error("cycle count before threshold");

    // Checks the value that actually leaves the block, not the counter's own mux
    a_cc_first_zero: assert property (@(posedge ref_clk) disable iff (!reset_n)
        commit_take && trace_enable && cc.emit && u_cc.first_reg
        |=> ##1 elem_payload == '0)
        else $error("first cycle count not zero");
endmodule

// file: pft_core_model.sv
`timescale 1ns/1ns
module pft_core_model (
    input  wire logic        ref_clk,
    input  wire logic        insn_ready,
    input  wire logic        commit_ready,
    output logic             insn_valid,
    output logic [31:0]      insn_addr,
    output logic             insn_is_branch,
    output logic             insn_taken,
    output logic             commit_valid,
    output logic [7:0]       commit_count
);
    initial begin
        insn_valid     = 1'b0;
        insn_addr      = 32'h0;
        insn_is_branch = 1'b0;
        insn_taken     = 1'b0;
        commit_valid   = 1'b0;
        commit_count   = 8'h0;
    end

    // Held until the edge that sees ready; the idle address flips so a stale value never matches
    task automatic issue(input logic [31:0] a, input logic br, input logic tk, output bit ok);
        int n;
        n = 0;
        @(posedge ref_clk);
        insn_valid     <= 1'b1;
        insn_addr      <= a;
        insn_is_branch <= br;
        insn_taken     <= tk;
        @(negedge ref_clk);
        while (insn_ready !== 1'b1 && n < 50) begin
            @(negedge ref_clk);
            n++;
        end
        ok = (insn_ready === 1'b1);
        @(posedge ref_clk);
        insn_valid <= 1'b0;
        insn_addr  <= ~a;
    endtask

    // One commit per atom set; count never exceeds the atoms still open
    task automatic commit(input logic [7:0] c, output bit ok);
        int n;
        n = 0;
        @(posedge ref_clk);
        commit_valid <= 1'b1;
        commit_count <= c;
        @(negedge ref_clk);
        while (commit_ready !== 1'b1 && n < 50) begin
            @(negedge ref_clk);
            n++;
        end
        ok = (commit_ready === 1'b1);
        @(posedge ref_clk);
        commit_valid <= 1'b0;
        commit_count <= ~c;
    endtask
endmodule

// file: testbench.sv
`timescale 1ns/1ns
module testbench
    import pft_pkg::*;
;
    localparam int THR = 16;
    logic        ref_clk, reset_n, trace_enable, start_addr_enable, cc_enable;
    logic [31:0] start_addr, insn_addr, elem_payload;
    logic [15:0] cc_threshold;
    logic        insn_valid, insn_is_branch, insn_taken, commit_valid, insn_ready;
    logic        commit_ready, elem_valid, tracing;
    logic [7:0]  commit_count;
    pft_elem_t   elem_kind;
    int          error_cnt = 0;
    int          comparisons = 0;
    int          cyc = 0;
    int          last_cc, pend, r;
    bit          first_cc, tr_m, ok;
    logic [35:0] exp_q[$];

    pft_trace_unit u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .trace_enable(trace_enable),
        .start_addr_enable(start_addr_enable), .start_addr(start_addr), .cc_enable(cc_enable),
        .cc_threshold(cc_threshold), .insn_valid(insn_valid), .insn_addr(insn_addr),
        .insn_is_branch(insn_is_branch), .insn_taken(insn_taken), .commit_valid(commit_valid),
        .commit_count(commit_count), .insn_ready(insn_ready), .commit_ready(commit_ready),
        .elem_valid(elem_valid), .elem_kind(elem_kind), .elem_payload(elem_payload),
        .tracing(tracing));
    pft_core_model u_core (.ref_clk(ref_clk), .insn_ready(insn_ready),
        .commit_ready(commit_ready), .insn_valid(insn_valid), .insn_addr(insn_addr),
        .insn_is_branch(insn_is_branch), .insn_taken(insn_taken),
        .commit_valid(commit_valid), .commit_count(commit_count));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) cyc <= cyc + 1;

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        comparisons++;
        if (seen !== want) begin
            error_cnt++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic report_and_stop();
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    always @(posedge ref_clk) begin
        if (reset_n && elem_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                check({28'h0, elem_kind}, 32'h0);
            end else begin
                check({28'h0, elem_kind}, {28'h0, exp_q[0][35:32]});
                check(elem_payload, exp_q[0][31:0]);
                void'(exp_q.pop_front());
            end
        end
    end

    task automatic do_insn(input logic [31:0] a, input logic br, input logic tk);
        u_core.issue(a, br, tk, ok);
        if (!ok) begin
            error_cnt++;
            report_and_stop();
        end
        if (!tr_m && (start_addr_enable === 1'b0 || a === start_addr)) begin
            tr_m = 1'b1;
            exp_q.push_back({PFT_EL_TRACE_INFO, 32'h0});
            exp_q.push_back({PFT_EL_TRACE_ON, 32'h0});
            exp_q.push_back({PFT_EL_CONTEXT, 32'h0});
            exp_q.push_back({PFT_EL_ADDRESS, a});
        end
        if (tr_m && br) begin
            exp_q.push_back({tk ? PFT_EL_ATOM_E : PFT_EL_ATOM_N, 32'h0});
            pend++;
        end
    endtask

    task automatic do_commit(input logic [7:0] n);
        int t;
        u_core.commit(n, ok);
        t = cyc;
        if (!ok) begin
            error_cnt++;
            report_and_stop();
        end
        pend -= n;
        exp_q.push_back({PFT_EL_COMMIT, 24'h0, n});
        if (cc_enable === 1'b1 && first_cc) begin
            first_cc = 1'b0;
            last_cc = t;
            exp_q.push_back({PFT_EL_CYCLE_CNT, 32'h0});
        end else if (cc_enable === 1'b1 && t - last_cc > int'(cc_threshold)) begin
            exp_q.push_back({PFT_EL_CYCLE_CNT, 32'(t - last_cc)});
            last_cc = t;
        end
    endtask

    initial begin
        repeat (100000) @(posedge ref_clk);
        error_cnt++;
        report_and_stop();
    end

    initial begin
        void'($urandom(90606));
        reset_n = 1'b0;
        trace_enable = 1'b0;
        start_addr_enable = 1'b0;
        start_addr = 32'h0;
        cc_enable = 1'b0;
        cc_threshold = 16'(THR);
        first_cc = 1'b1;
        tr_m = 1'b0;
        pend = 0;
        repeat (3) @(posedge ref_clk);
        reset_n <= 1'b1;
        check({31'h0, tracing}, 32'h0);
        @(posedge ref_clk);
        trace_enable <= 1'b1;
        start_addr_enable <= 1'b1;
        start_addr <= 32'h1000;
        cc_enable <= 1'b1;
        do_insn(32'h0ff0, 1'b1, 1'b1);
        do_insn(32'h1000, 1'b1, 1'b1);
        for (int i = 0; i < 3; i++)
            do_insn(32'h2000 + 32'(4 * i), 1'b0, 1'b0);
        check({31'h0, tracing}, 32'h1);
        do_commit(8'h1);
        do_insn(32'h200c, 1'b1, 1'b0);
        do_commit(8'h1);
        // Gaps straddle the threshold so the strict boundary is hit both ways
        for (int g = 8; g <= 20; g++) begin
            do_insn($urandom, 1'b1, 1'b1);
            repeat (g) @(posedge ref_clk);
            do_commit(8'h1);
        end
        // Threshold is programmable, so the random run draws a value from 4 to 24
        cc_threshold <= 16'($urandom_range(24, 4));
        for (int i = 0; i < 300; i++) begin
            r = $urandom_range(9);
            if (r < 6)
                do_insn($urandom, r < 3, r[0]);
            else if (r < 8 && pend > 0)
                do_commit(8'($urandom_range(pend > 8 ? 8 : pend, 1)));
            else
                repeat ($urandom_range(20)) @(posedge ref_clk);
        end
        repeat (6) @(posedge ref_clk);
        trace_enable <= 1'b0;
        tr_m = 1'b0;
        first_cc = 1'b1;
        repeat (3) @(posedge ref_clk);
        check({31'h0, tracing}, 32'h0);
        trace_enable <= 1'b1;
        start_addr_enable <= 1'b0;
        // Counting off: the commit below must go out without a cycle count
        cc_enable <= 1'b0;
        do_insn(32'h7000, 1'b1, 1'b0);
        do_commit(8'h1);
        repeat (12) @(posedge ref_clk);
        check(32'(exp_q.size()), 32'h0);
        report_and_stop();
    end
endmodule
